// ===== sensor_fifo_pkg.sv
package sensor_fifo_pkg;

    // ****************************************
    // storage geometry
    // ****************************************
    localparam int              ADDR_W         = 9;
    localparam logic [9:0]      DEPTH_BYTES    = 10'h200;
    localparam logic [9:0]      MAX_FRAME_LEN  = 10'h009;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [6:0]      ADDR_COUNT_LOW  = 7'h00;
    localparam logic [6:0]      ADDR_COUNT_HIGH = 7'h01;
    localparam logic [6:0]      ADDR_DATA       = 7'h02;
    localparam logic [6:0]      ADDR_CONF_A     = 7'h03;
    localparam logic [6:0]      ADDR_CONF_B     = 7'h04;
    localparam logic [6:0]      ADDR_COMMAND    = 7'h05;

    localparam int              BIT_COLLECT_EN  = 0;
    localparam int              BIT_STOP_FULL   = 1;
    localparam int              BIT_TIME_EN     = 2;
    localparam int              BIT_PRESS_EN    = 3;
    localparam int              BIT_TEMP_EN     = 4;
    localparam int              POS_SUBSAMPLE   = 0;
    localparam int              POS_DATA_SEL    = 3;

    localparam logic [7:0]      CONF_A_RESET    = 8'h00;
    localparam logic [7:0]      CONF_B_RESET    = 8'h00;
    localparam logic [4:0]      CONF_A_MASK     = 5'h1F;
    localparam logic [4:0]      CONF_B_MASK     = 5'h1F;

    localparam logic [7:0]      CMD_FLUSH       = 8'hB0;
    localparam logic [7:0]      CMD_SOFT_RESET  = 8'hB6;
    localparam logic [1:0]      SEL_FILTERED    = 2'h1;

    // ****************************************
    // frame format
    // ****************************************
    localparam logic [1:0]      KIND_SENSOR     = 2'h2;
    localparam logic [1:0]      KIND_CONTROL    = 2'h1;
    localparam logic [3:0]      PARAM_CFG_ERROR = 4'h1;
    localparam logic [3:0]      PARAM_CFG_CHG   = 4'h2;
    localparam logic [7:0]      CTRL_OPCODE     = 8'h01;
    localparam logic [7:0]      HDR_EMPTY       = 8'h80;
    localparam logic [7:0]      HDR_TIME        = 8'hA0;
    localparam logic [7:0]      EMPTY_DATA      = 8'h00;

    typedef enum logic [2:0] {
        W_IDLE,
        W_CHECK,
        W_DROP_ADDR,
        W_DROP_HDR,
        W_WRITE
    } writer_state_t;

    function automatic logic [3:0] frame_len(input logic [7:0] hdr);
        logic [3:0] len;
        len = 4'h1;
        if (hdr[7:6] == KIND_CONTROL) begin
            len = 4'h2;
        end else begin
            if (hdr[4]) len = len + 4'h3;
            if (hdr[2]) len = len + 4'h3;
        end
        return len;
    endfunction

endpackage

// ===== fifo_byte_ram.sv
module fifo_byte_ram (
    input  wire logic                                clock,
    input  wire logic                                wr_en,
    input  wire logic [sensor_fifo_pkg::ADDR_W-1:0]  wr_addr,
    input  wire logic [7:0]                          wr_data,
    input  wire logic [sensor_fifo_pkg::ADDR_W-1:0]  rd_addr,
    output logic      [7:0]                          rd_data
);

    // ****************************************
    // storage, registered read
    // ****************************************
    logic [7:0] mem [0:(1 << sensor_fifo_pkg::ADDR_W)-1];

    always_ff @(posedge clock) begin
        if (wr_en) mem[wr_addr] <= wr_data;
        rd_data <= mem[rd_addr];
    end

endmodule

// ===== sensor_sample_fifo.sv
module sensor_sample_fifo (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        csb_n,
    input  wire logic        sck,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe,
    input  wire logic        sample_valid,
    output logic             sample_ready,
    input  wire logic [23:0] press_raw,
    input  wire logic [23:0] press_filt,
    input  wire logic [23:0] temp_raw,
    input  wire logic [23:0] temp_filt,
    input  wire logic        normal_mode,
    input  wire logic        config_error,
    input  wire logic        config_change,
    input  wire logic [23:0] sensor_time
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] pin_raw;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [2:0] pin_last;

    assign pin_raw = {sdi, sck, csb_n};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                pin_meta[gi] <= pin_raw[gi];
                pin_sync[gi] <= pin_meta[gi];
                pin_last[gi] <= pin_sync[gi];
            end
        end
    endgenerate

    wire cs_active = ~pin_sync[0];
    wire cs_rise   = pin_sync[0] & ~pin_last[0];
    wire sck_rise  = pin_sync[1] & ~pin_last[1];
    wire sck_fall  = ~pin_sync[1] & pin_last[1];
    wire sdi_s     = pin_sync[2];

    // ****************************************
    // serial register port
    // ****************************************
    logic [2:0] bit_cnt;
    logic [6:0] rx_sh;
    logic [7:0] tx_sh;
    logic       hdr_phase;
    logic       rw_read;
    logic [6:0] reg_addr;
    logic [7:0] conf_a;
    logic [7:0] conf_b;
    logic [7:0] rd_value;
    logic [7:0] fifo_byte;
    logic [8:0] count;

    wire [7:0] rx_byte   = {rx_sh, sdi_s};
    wire       byte_done = cs_active & sck_rise & (bit_cnt == 3'h7);
    wire       reg_wr    = byte_done & ~hdr_phase & ~rw_read;
    wire       load_tx   = cs_active & sck_fall & (bit_cnt == 3'h0) & ~hdr_phase & rw_read;
    wire       shift_tx  = cs_active & sck_fall & (bit_cnt != 3'h0) & ~hdr_phase & rw_read;
    wire       data_take = load_tx & (reg_addr == sensor_fifo_pkg::ADDR_DATA);

    always_ff @(posedge clock) begin
        if (sys_rst || !cs_active) begin
            bit_cnt   <= 3'h0;
            hdr_phase <= 1'b1;
            rw_read   <= 1'b0;
            if (sys_rst) reg_addr <= 7'h00;
        end else if (sck_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sh   <= rx_byte[6:0];
            if (bit_cnt == 3'h7) begin
                hdr_phase <= 1'b0;
                if (hdr_phase) begin
                    rw_read  <= rx_byte[7];
                    reg_addr <= rx_byte[6:0];
                end else if (reg_addr != sensor_fifo_pkg::ADDR_DATA) begin
                    reg_addr <= reg_addr + 7'h01;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_sh  <= 8'h00;
            sdo    <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= cs_active & rw_read & ~hdr_phase;
            if (load_tx) begin
                tx_sh <= {rd_value[6:0], 1'b0};
                sdo   <= rd_value[7];
            end else if (shift_tx) begin
                tx_sh <= {tx_sh[6:0], 1'b0};
                sdo   <= tx_sh[7];
            end
        end
    end

    assign rd_value = (reg_addr == sensor_fifo_pkg::ADDR_COUNT_LOW)  ? count[7:0] :
                      (reg_addr == sensor_fifo_pkg::ADDR_COUNT_HIGH) ? {7'h00, count[8]} :
                      (reg_addr == sensor_fifo_pkg::ADDR_DATA)       ? fifo_byte :
                      (reg_addr == sensor_fifo_pkg::ADDR_CONF_A)     ? conf_a :
                      (reg_addr == sensor_fifo_pkg::ADDR_CONF_B)     ? conf_b : 8'h00;

    // ****************************************
    // configuration and commands
    // ****************************************
    wire wr_conf_a = reg_wr & (reg_addr == sensor_fifo_pkg::ADDR_CONF_A);
    wire wr_conf_b = reg_wr & (reg_addr == sensor_fifo_pkg::ADDR_CONF_B);
    wire wr_cmd    = reg_wr & (reg_addr == sensor_fifo_pkg::ADDR_COMMAND);
    wire soft_rst  = wr_cmd & (rx_byte == sensor_fifo_pkg::CMD_SOFT_RESET);
    wire flush     = wr_cmd & ((rx_byte == sensor_fifo_pkg::CMD_FLUSH) | soft_rst);
    wire clear_all = sys_rst | flush;

    wire       collect_en  = conf_a[sensor_fifo_pkg::BIT_COLLECT_EN];
    wire       stop_full   = conf_a[sensor_fifo_pkg::BIT_STOP_FULL];
    wire       time_en     = conf_a[sensor_fifo_pkg::BIT_TIME_EN];
    wire       press_en    = conf_a[sensor_fifo_pkg::BIT_PRESS_EN];
    wire       temp_en     = conf_a[sensor_fifo_pkg::BIT_TEMP_EN];
    wire [2:0] subsample   = conf_b[sensor_fifo_pkg::POS_SUBSAMPLE +: 3];
    wire [1:0] data_sel    = conf_b[sensor_fifo_pkg::POS_DATA_SEL +: 2];
    wire       write_on    = collect_en & (press_en | temp_en);

    always_ff @(posedge clock) begin
        if (sys_rst || soft_rst) begin
            conf_a <= sensor_fifo_pkg::CONF_A_RESET;
            conf_b <= sensor_fifo_pkg::CONF_B_RESET;
        end else begin
            if (wr_conf_a) conf_a <= {3'h0, rx_byte[4:0] & sensor_fifo_pkg::CONF_A_MASK};
            if (wr_conf_b) conf_b <= {3'h0, rx_byte[4:0] & sensor_fifo_pkg::CONF_B_MASK};
        end
    end

    // ****************************************
    // two-entry sample buffer
    // ****************************************
    logic [47:0] sb_data [0:1];
    logic        sb_wp;
    logic        sb_rp;
    logic [1:0]  sb_cnt;
    logic        sb_pop;

    wire        sb_push  = sample_valid & sample_ready;
    wire        sel_filt = (data_sel == sensor_fifo_pkg::SEL_FILTERED);
    wire [47:0] sb_in    = sel_filt ? {temp_filt, press_filt} : {temp_raw, press_raw};
    wire [47:0] sb_head  = sb_data[sb_rp];
    wire        sb_valid = (sb_cnt != 2'h0);
    wire [1:0]  sb_next  = sb_cnt + {1'b0, sb_push} - {1'b0, sb_pop};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sb_wp        <= 1'b0;
            sb_rp        <= 1'b0;
            sb_cnt       <= 2'h0;
            sample_ready <= 1'b0;
        end else begin
            if (sb_push) sb_data[sb_wp] <= sb_in;
            if (sb_push) sb_wp <= ~sb_wp;
            if (sb_pop) sb_rp <= ~sb_rp;
            sb_cnt       <= sb_next;
            sample_ready <= (sb_next != 2'h2);
        end
    end

    // ****************************************
    // down-sampling
    // ****************************************
    logic [6:0] ds_cnt;
    logic       normal_d;

    wire       normal_rise = normal_mode & ~normal_d;
    wire [6:0] ds_shift    = 7'h7F << subsample;
    wire [6:0] ds_mask     = ~ds_shift;
    wire       ds_keep     = ~normal_mode | ((ds_cnt & ds_mask) == 7'h00);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ds_cnt   <= 7'h00;
            normal_d <= 1'b0;
        end else begin
            normal_d <= normal_mode;
            if (normal_rise) ds_cnt <= 7'h00;
            else if (sb_pop && normal_mode) ds_cnt <= ds_cnt + 7'h01;
        end
    end

    // ****************************************
    // frame writer
    // ****************************************
    sensor_fifo_pkg::writer_state_t w_state;
    logic [7:0]  fbuf [0:6];
    logic [3:0]  flen;
    logic [3:0]  widx;
    logic        w_is_chg;
    logic        err_pend;
    logic        chg_pend;
    logic [8:0]  wptr;
    logic [8:0]  rptr;
    logic [3:0]  rd_off;
    logic [3:0]  this_len;
    logic        rd_commit;
    logic [7:0]  mem_q;

    wire [9:0] free_bytes = sensor_fifo_pkg::DEPTH_BYTES - {1'b0, count};
    wire       is_full    = free_bytes < sensor_fifo_pkg::MAX_FRAME_LEN;
    wire       in_idle    = (w_state == sensor_fifo_pkg::W_IDLE);
    wire       w_commit   = (w_state == sensor_fifo_pkg::W_WRITE) & (widx == flen - 4'h1);
    wire       drop_busy  = (w_state == sensor_fifo_pkg::W_DROP_ADDR) |
                            (w_state == sensor_fifo_pkg::W_DROP_HDR);
    wire       drop_adv   = (w_state == sensor_fifo_pkg::W_DROP_HDR) & ~rd_commit;
    wire [3:0] drop_len   = sensor_fifo_pkg::frame_len(mem_q);
    wire       take_err   = in_idle & err_pend;
    wire       take_smp   = in_idle & ~err_pend & sb_valid;
    wire       smp_store  = write_on & ds_keep;
    wire       take_chg   = take_smp & smp_store & chg_pend;
    wire [7:0] sens_hdr   = {sensor_fifo_pkg::KIND_SENSOR, 1'b0, temp_en, 1'b0, press_en, 2'b00};
    wire [7:0] err_hdr    = {sensor_fifo_pkg::KIND_CONTROL, sensor_fifo_pkg::PARAM_CFG_ERROR, 2'b00};
    wire [7:0] chg_hdr    = {sensor_fifo_pkg::KIND_CONTROL, sensor_fifo_pkg::PARAM_CFG_CHG, 2'b00};
    wire       chg_set    = (config_change | wr_conf_a | wr_conf_b) & normal_mode & write_on;

    assign sb_pop = take_smp & ~take_chg;

    always_ff @(posedge clock) begin
        if (clear_all) begin
            w_state  <= sensor_fifo_pkg::W_IDLE;
            widx     <= 4'h0;
            flen     <= 4'h0;
            w_is_chg <= 1'b0;
        end else begin
            unique case (w_state)
                sensor_fifo_pkg::W_IDLE: begin
                    widx <= 4'h0;
                    if (take_err || take_chg) begin
                        fbuf[0]  <= take_err ? err_hdr : chg_hdr;
                        fbuf[1]  <= sensor_fifo_pkg::CTRL_OPCODE;
                        flen     <= 4'h2;
                        w_is_chg <= take_chg;
                        w_state  <= sensor_fifo_pkg::W_CHECK;
                    end else if (take_smp && smp_store) begin
                        fbuf[0]  <= sens_hdr;
                        {fbuf[3], fbuf[2], fbuf[1]} <= temp_en ? sb_head[47:24] : sb_head[23:0];
                        {fbuf[6], fbuf[5], fbuf[4]} <= sb_head[23:0];
                        flen     <= sensor_fifo_pkg::frame_len(sens_hdr);
                        w_is_chg <= 1'b0;
                        w_state  <= sensor_fifo_pkg::W_CHECK;
                    end
                end
                sensor_fifo_pkg::W_CHECK: begin
                    if (!is_full) w_state <= sensor_fifo_pkg::W_WRITE;
                    else if (stop_full) w_state <= sensor_fifo_pkg::W_IDLE;
                    else w_state <= sensor_fifo_pkg::W_DROP_ADDR;
                end
                sensor_fifo_pkg::W_DROP_ADDR: begin
                    if (!rd_commit) w_state <= sensor_fifo_pkg::W_DROP_HDR;
                end
                sensor_fifo_pkg::W_DROP_HDR: begin
                    w_state <= rd_commit ? sensor_fifo_pkg::W_DROP_ADDR : sensor_fifo_pkg::W_CHECK;
                end
                sensor_fifo_pkg::W_WRITE: begin
                    widx <= widx + 4'h1;
                    if (w_commit) w_state <= sensor_fifo_pkg::W_IDLE;
                end
            endcase
        end
    end

    // set wins over clear for both pending control frames
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            err_pend <= 1'b0;
            chg_pend <= 1'b0;
        end else begin
            err_pend <= (config_error & write_on) | (err_pend & ~take_err & ~flush);
            chg_pend <= chg_set | (chg_pend & ~(w_commit & w_is_chg) & ~flush);
        end
    end

    // ****************************************
    // pointers and byte count
    // ****************************************
    // update on whole frames only
    wire [8:0] w_add = w_commit ? {5'h00, flen} : 9'h000;
    wire [8:0] r_sub = rd_commit ? {5'h00, this_len} :
                       drop_adv  ? {5'h00, drop_len} : 9'h000;

    always_ff @(posedge clock) begin
        if (clear_all) begin
            wptr  <= 9'h000;
            rptr  <= 9'h000;
            count <= 9'h000;
        end else begin
            count <= count + w_add - r_sub;
            if (w_commit) wptr <= wptr + {5'h00, flen};
            if (rd_commit || drop_adv) rptr <= rptr + r_sub;
        end
    end

    wire [8:0] ram_wr_addr = wptr + {5'h00, widx};
    wire [8:0] ram_rd_addr = drop_busy ? rptr : rptr + {5'h00, rd_off};

    fifo_byte_ram u_ram (
        .clock   (clock),
        .wr_en   (w_state == sensor_fifo_pkg::W_WRITE),
        .wr_addr (ram_wr_addr),
        .wr_data (fbuf[widx[2:0]]),
        .rd_addr (ram_rd_addr),
        .rd_data (mem_q)
    );

    // ****************************************
    // frame reader
    // ****************************************
    // a data read landing inside a two-cycle drop sees the header byte; rare, accepted
    logic [3:0]  cur_len;
    logic [1:0]  time_idx;
    logic        time_done;
    logic        empty_idx;
    logic [23:0] time_snap;
    logic [7:0]  time_byte;

    wire have_frames = (count != 9'h000);
    wire time_turn   = ~have_frames & time_en & ~time_done;

    assign this_len  = (rd_off == 4'h0) ? sensor_fifo_pkg::frame_len(mem_q) : cur_len;
    assign rd_commit = data_take & have_frames & (rd_off == this_len - 4'h1);
    assign time_byte = (time_idx == 2'h0) ? sensor_fifo_pkg::HDR_TIME :
                       (time_idx == 2'h1) ? time_snap[7:0] :
                       (time_idx == 2'h2) ? time_snap[15:8] : time_snap[23:16];
    assign fifo_byte = have_frames ? mem_q :
                       time_turn   ? time_byte :
                       empty_idx   ? sensor_fifo_pkg::EMPTY_DATA : sensor_fifo_pkg::HDR_EMPTY;

    always_ff @(posedge clock) begin
        if (clear_all || cs_rise) begin
            rd_off    <= 4'h0;
            time_idx  <= 2'h0;
            time_done <= 1'b0;
            empty_idx <= 1'b0;
            if (clear_all) cur_len <= 4'h0;
        end else if (drop_adv) begin
            rd_off <= 4'h0;
        end else if (data_take) begin
            if (have_frames) begin
                if (rd_off == 4'h0) cur_len <= this_len;
                rd_off <= rd_commit ? 4'h0 : rd_off + 4'h1;
            end else if (time_turn) begin
                if (time_idx == 2'h0) time_snap <= sensor_time;
                time_idx <= time_idx + 2'h1;
                if (time_idx == 2'h3) time_done <= 1'b1;
            end else begin
                empty_idx <= ~empty_idx;
            end
        end
    end

endmodule

// ===== sensor_sample_fifo_assertions.sv
module fifo_port_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic csb_n,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic sample_valid,
    input wire logic sample_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // port rules
    // ****
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // an answer needs a whole command byte first, so count select-low cycles
    logic [7:0] low_cnt;
    always_ff @(posedge clock) begin
        if (csb_n) low_cnt <= 8'h00;
        else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
    end
    sequence csb_idle;
        csb_n [*5];
    endsequence
    chk_reset_quiet: assert property (disable iff (1'b0)
        sys_rst |=> !sdo && !sdo_oe && !sample_ready) else $error("output active in reset");
    chk_ready_release: assert property ($fell(sys_rst) |=> sample_ready)
        else $error("ready late after reset");
    chk_ready_cause: assert property ($fell(sample_ready) |->
        $past(sample_valid) || $past(sample_valid, 2)) else $error("ready fell unprompted");
    chk_ready_hold: assert property (sample_ready && !sample_valid |=> sample_ready)
        else $error("ready dropped while idle");
    chk_ready_return: assert property (!sample_ready |-> ##[1:200] sample_ready)
        else $error("writer stalled");
    chk_oe_release: assert property (csb_idle |-> !sdo_oe)
        else $error("sdo driven while deselected");
    chk_oe_hold: assert property (sdo_oe && !csb_n |=> sdo_oe)
        else $error("sdo released inside burst");
    chk_oe_after_cmd: assert property ($rose(sdo_oe) |-> low_cnt > 8'h30)
        else $error("sdo driven before command byte");
endmodule

bind sensor_sample_fifo fifo_port_checker i_chk (
    .clock(clock), .sys_rst(sys_rst), .csb_n(csb_n), .sdo(sdo), .sdo_oe(sdo_oe),
    .sample_valid(sample_valid), .sample_ready(sample_ready));

// ===== spi_host_model.sv
module spi_host_model (
    input  wire logic clock,
    output logic      csb_n,
    output logic      sck,
    output logic      sdi,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx [0:15];
    initial begin
        csb_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // ****
    // mode 0 transfer, 160 ns bit period
    // ****
    // host register transfers, writes and reads
    task automatic xfer(input logic [7:0] hdr, input int nbits, input logic [7:0] wd);
        logic [7:0] sh;
        sh = hdr;
        csb_n = 1'b0;
        for (int i = 0; i < nbits + 8; i++) begin
            sdi = sh[7];
            sh = (i == 7) ? wd : {sh[6:0], 1'b0};
            repeat (4) @(negedge clock);
            sck = 1'b1;
            repeat (4) @(negedge clock);
            // sample just before the fall: sdo moves a few clocks after it
            if (i >= 8) rx[(i - 8) / 8] = {rx[(i - 8) / 8][6:0], sdo};
            sck = 1'b0;
        end
        repeat (4) @(negedge clock);
        csb_n = 1'b1;
        // a released line must not keep its last level
        sdi = ~sdi;
        repeat (8) @(negedge clock);
    endtask
endmodule

// ===== tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] LO  = sensor_fifo_pkg::ADDR_COUNT_LOW;
    localparam logic [6:0] DAT = sensor_fifo_pkg::ADDR_DATA;
    localparam logic [6:0] CA  = sensor_fifo_pkg::ADDR_CONF_A;
    localparam logic [6:0] CB  = sensor_fifo_pkg::ADDR_CONF_B;
    localparam logic [6:0] CMD = sensor_fifo_pkg::ADDR_COMMAND;
    logic        clock, sys_rst, csb_n, sck, sdi, sdo, sample_valid, sample_ready;
    logic        normal_mode, config_error, config_change;
    logic [23:0] temp_raw, press_raw, stime;
    int          bad_count, n_tests;
    sensor_sample_fifo i_dut (
        .clock(clock), .sys_rst(sys_rst), .csb_n(csb_n), .sck(sck), .sdi(sdi), .sdo(sdo),
        .sdo_oe(), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .press_raw(press_raw), .press_filt(~press_raw), .temp_raw(temp_raw),
        .temp_filt(~temp_raw), .normal_mode(normal_mode), .config_error(config_error),
        .config_change(config_change), .sensor_time(stime));
    spi_host_model i_host (.clock(clock), .csb_n(csb_n), .sck(sck), .sdi(sdi), .sdo(sdo));
    // ****
    // tasks
    // ****
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_host.xfer({1'b0, a}, 8, d);
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] e [$]);
        i_host.xfer({1'b1, a}, 8 * e.size(), 8'h00);
        foreach (e[j]) check(i_host.rx[j], e[j]);
    endtask
    // back-to-back offers; temperature steps by one per accepted sample
    task automatic sample(input logic [23:0] t, input logic [23:0] p, input int n);
        int acc;
        int k;
        acc = 0;
        k = 0;
        temp_raw = t;
        press_raw = p;
        sample_valid = 1'b1;
        // a full buffer takes nine cycles per frame, so long runs need room
        while (acc < n && k < 2000) begin
            if (sample_ready === 1'b1) acc++;
            @(negedge clock);
            k++;
            temp_raw = t + 24'(acc);
        end
        sample_valid = 1'b0;
        if (acc < n) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, acc, n);
            end_sim();
        end
        repeat (40) @(negedge clock);
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (100000) @(posedge clock);
        bad_count++;
        end_sim();
    end
    initial begin
        sys_rst = 1'b1;
        sample_valid = 1'b0;
        normal_mode = 1'b0;
        config_error = 1'b0;
        config_change = 1'b0;
        temp_raw = 24'h000000;
        press_raw = 24'h000000;
        stime = 24'h332211;
        repeat (20) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        rdchk(LO, '{8'h00, 8'h00, 8'h80, 8'h00, 8'h80});
        wr(CB, 8'h08);
        wr(CA, 8'h19);
        sample(24'h030201, 24'h060504, 1);
        rdchk(LO, '{8'h07});
        rdchk(DAT, '{8'h94, 8'hFE, 8'hFD, 8'hFC, 8'hFB, 8'hFA, 8'hF9, 8'h80});
        rdchk(LO, '{8'h00});
        wr(CA, 8'h04);
        rdchk(DAT, '{8'hA0, 8'h11, 8'h22, 8'h33, 8'h80, 8'h00});
        wr(CB, 8'h00);
        wr(CA, 8'h09);
        sample(24'h000000, 24'h0C0B0A, 1);
        i_host.xfer({1'b1, DAT}, 12, 8'h00);
        rdchk(DAT, '{8'h84, 8'h0A, 8'h0B, 8'h0C});
        config_error = 1'b1;
        @(negedge clock);
        config_error = 1'b0;
        repeat (20) @(negedge clock);
        rdchk(DAT, '{8'h44, 8'h01, 8'h80});
        sample(24'h000000, 24'h0F0E0D, 1);
        wr(CA, 8'h08);
        sample(24'h000000, 24'h111111, 1);
        wr(7'h10, 8'h55);
        wr(CMD, 8'h11);
        rdchk(LO, '{8'h04});
        rdchk(7'h10, '{8'h00});
        rdchk(DAT, '{8'h84, 8'h0D, 8'h0E, 8'h0F, 8'h80});
        wr(CA, 8'h09);
        sample(24'h000000, 24'h000001, 1);
        wr(CMD, 8'hB0);
        rdchk(LO, '{8'h00});
        sample(24'h000000, 24'h000001, 1);
        wr(CMD, 8'hB6);
        rdchk(LO, '{8'h00});
        rdchk(CA, '{8'h00});
        wr(CB, 8'h01);
        wr(CA, 8'h09);
        normal_mode = 1'b1;
        sample(24'h000000, 24'h000002, 3);
        rdchk(LO, '{8'h08});
        wr(CMD, 8'hB0);
        // odd down-sample count left behind: only a wake restart keeps the next sample
        normal_mode = 1'b0;
        @(negedge clock);
        normal_mode = 1'b1;
        config_change = 1'b1;
        @(negedge clock);
        config_change = 1'b0;
        sample(24'h000000, 24'h030303, 1);
        rdchk(DAT, '{8'h48, 8'h01, 8'h84, 8'h03, 8'h03, 8'h03});
        normal_mode = 1'b0;
        wr(CB, 8'h07);
        wr(CMD, 8'hB0);
        wr(CA, 8'h1B);
        sample(24'h000000, 24'h000007, 80);
        rdchk(LO, '{8'hF8, 8'h01});
        wr(CA, 8'h19);
        sample(24'h000050, 24'h000007, 3);
        rdchk(LO, '{8'hF8, 8'h01, 8'h94, 8'h03});
        end_sim();
    end
endmodule
